//--- rtl/adr_pkg.sv
// constants shared by both ends of the serial result reader link
// assumes the host runs on a 250 MHz reference clock and makes the serial clock
package adr_pkg;

    localparam int unsigned REF_CLK_HZ    = 250_000_000;
    localparam int unsigned SCLK_MAX_HZ   = 200_000;
    // least half period of the serial clock, rounded up so the rate never exceeds the limit
    localparam int unsigned SCLK_HALF_CYC = (REF_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam int unsigned DIV_W         = 10;
    localparam logic [DIV_W-1:0] SCLK_HALF_LAST = DIV_W'(SCLK_HALF_CYC - 1);

    localparam int unsigned BYTE_BITS  = 8;
    localparam int unsigned XFER_BYTES = 3;
    localparam int unsigned FRAME_BITS = BYTE_BITS * XFER_BYTES;
    localparam int unsigned RES_BITS   = 12;
    localparam int unsigned CNT_W      = 5;

    localparam logic [CNT_W-1:0] BYTE0_LAST = 5'h07;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
    localparam logic [CNT_W-1:0] FRAME_DONE = 5'h18;

    localparam logic [7:0] CH0_GND_WORD = 8'h08;
    localparam logic [7:0] MID_MASK     = 8'h1F;
    localparam logic [7:0] LOW_MASK     = 8'hFE;
    localparam logic [10:0] FRAME_PAD   = 11'h000;

    typedef enum logic [2:0] {
        ADR_IDLE  = 3'h0,
        ADR_SETUP = 3'h1,
        ADR_SHIFT = 3'h3,
        ADR_END   = 3'h2,
        ADR_GAP   = 3'h6
    } adr_state_t;

endpackage

//--- rtl/adr_link_if.sv
// serial link between host and converter: clock, select, data in, data out
// assumes the converter output idles high when deselected (pull-up on the wire)
`timescale 1ns/1ns
`default_nettype none
interface adr_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    wire  miso;

    assign miso = miso_oe_n ? 1'b1 : miso_o;

    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input  miso
    );

    modport dev (
        input  sclk,
        input  cs_n,
        input  mosi,
        output miso_o,
        output miso_oe_n
    );
endinterface // adr_link_if
`default_nettype wire

//--- rtl/adr_dev_end.sv
// converter end of the link: takes the input word, returns the 12-bit result
// assumes mode 0 timing and that sample_data is held steady by the user across a frame
`timescale 1ns/1ns
`default_nettype none
module adr_dev_end (
    adr_link_if.dev              link,
    input  wire logic            sys_rst,
    input  wire logic [11:0]     sample_data,
    output logic [7:0]           cmd_word,
    output logic                 cmd_valid
);
    logic [adr_pkg::CNT_W-1:0]      bit_cnt_q;
    logic [6:0]                     din_sh_q;
    logic [adr_pkg::RES_BITS-1:0]   result_q;
    logic [7:0]                     cmd_word_q;
    logic                           cmd_valid_q;
    logic                           miso_q;
    logic [adr_pkg::FRAME_BITS-1:0] frame;
    logic                           frame_rst;

    // deselect clears the frame, since the link clock stops between frames
    assign frame_rst = sys_rst | link.cs_n;
    assign frame     = {adr_pkg::FRAME_PAD, result_q, 1'b0};

    always_ff @(posedge link.sclk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_q <= '0;
        end else if (bit_cnt_q != adr_pkg::FRAME_DONE) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge link.sclk or posedge frame_rst) begin
        if (frame_rst) begin
            din_sh_q <= '0;
        end else if (bit_cnt_q < adr_pkg::BYTE0_LAST) begin
            din_sh_q <= {din_sh_q[5:0], link.mosi};
        end
    end

    always_ff @(posedge link.sclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_word_q  <= '0;
            cmd_valid_q <= 1'b0;
            result_q    <= '0;
        end else if (!link.cs_n && bit_cnt_q == adr_pkg::BYTE0_LAST) begin
            cmd_word_q  <= {din_sh_q, link.mosi};
            cmd_valid_q <= 1'b1;
            result_q    <= sample_data;
        end else begin
            cmd_valid_q <= 1'b0;
        end
    end

    // launch on the falling edge so the host samples a settled bit on the rising one
    always_ff @(negedge link.sclk or posedge frame_rst) begin
        if (frame_rst) begin
            miso_q <= 1'b0;
        end else if (bit_cnt_q <= adr_pkg::FRAME_LAST) begin
            miso_q <= frame[adr_pkg::FRAME_LAST - bit_cnt_q];
        end else begin
            miso_q <= 1'b0;
        end
    end

    assign link.miso_o    = miso_q;
    assign link.miso_oe_n = link.cs_n;
    assign cmd_word       = cmd_word_q;
    assign cmd_valid      = cmd_valid_q;
endmodule // adr_dev_end
`default_nettype wire

//--- rtl/adr_host_end.sv
// host end of the link: runs one three-byte exchange per start request taken in idle; a start while busy is ignored
// assumes a 250 MHz ref_clk; the serial clock is divided down and driven out
`timescale 1ns/1ns
`default_nettype none
module adr_host_end (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic        cmd_default,
    input  wire logic [7:0]  cmd_word,
    output logic             busy,
    output logic [11:0]      result,
    output logic             result_valid,
    output logic [7:0]       rx_byte,
    output logic             rx_byte_valid,
    adr_link_if.host         link
);
    adr_pkg::adr_state_t            state_q;
    adr_pkg::adr_state_t            state_d;
    logic [adr_pkg::DIV_W-1:0]      div_q;
    logic                           tick;
    logic                           sclk_q;
    logic                           cs_n_q;
    logic                           rise;
    logic                           fall;
    logic [adr_pkg::CNT_W-1:0]      bit_cnt_q;
    logic [adr_pkg::FRAME_BITS-1:0] tx_q;
    logic [7:0]                     rx_q;
    logic [7:0]                     rx_next;
    logic [7:0]                     rx_byte_q;
    logic                           rx_byte_valid_q;
    logic [7:0]                     mid_q;
    logic [7:0]                     low_q;
    logic [15:0]                    joined;
    logic [11:0]                    result_q;
    logic                           result_valid_q;
    logic                           miso_meta_q;
    logic                           miso_sync_q;
    logic                           byte_end;

    // miso is a pin from another domain
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            miso_meta_q <= 1'b1;
            miso_sync_q <= 1'b1;
        end else begin
            miso_meta_q <= link.miso;
            miso_sync_q <= miso_meta_q;
        end
    end

    assign tick     = (div_q == adr_pkg::SCLK_HALF_LAST);
    assign rise     = (state_q == adr_pkg::ADR_SHIFT) && tick && !sclk_q;
    assign fall     = (state_q == adr_pkg::ADR_SHIFT) && tick && sclk_q;
    assign byte_end = fall && (bit_cnt_q[2:0] == 3'h7);
    assign rx_next  = {rx_q[6:0], miso_sync_q};

    // half-period divider keeps every serial clock phase at least 625 cycles
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
        end else if (state_q == adr_pkg::ADR_IDLE || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 10'h001;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            adr_pkg::ADR_IDLE: begin
                if (start) begin
                    state_d = adr_pkg::ADR_SETUP;
                end
            end
            adr_pkg::ADR_SETUP: begin
                if (tick) begin
                    state_d = adr_pkg::ADR_SHIFT;
                end
            end
            adr_pkg::ADR_SHIFT: begin
                if (fall && bit_cnt_q == adr_pkg::FRAME_LAST) begin
                    state_d = adr_pkg::ADR_END;
                end
            end
            adr_pkg::ADR_END: begin
                if (tick) begin
                    state_d = adr_pkg::ADR_GAP;
                end
            end
            adr_pkg::ADR_GAP: begin
                if (tick) begin
                    state_d = adr_pkg::ADR_IDLE;
                end
            end
            default: begin
                state_d = adr_pkg::ADR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= adr_pkg::ADR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // select covers setup, all 24 bits and a trailing half period
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_n_q <= 1'b1;
        end else begin
            cs_n_q <= !(state_d == adr_pkg::ADR_SETUP ||
                        state_d == adr_pkg::ADR_SHIFT ||
                        state_d == adr_pkg::ADR_END);
        end
    end

    // clock idles low and toggles only while shifting
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
        end else if (state_q == adr_pkg::ADR_SHIFT && tick) begin
            sclk_q <= !sclk_q;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_q <= '0;
        end else if (state_q == adr_pkg::ADR_IDLE) begin
            bit_cnt_q <= '0;
        end else if (fall) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // the loaded word leads the frame; the two trailing bytes are zero fill
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_q <= '0;
        end else if (state_q == adr_pkg::ADR_IDLE && start) begin
            if (cmd_default) begin
                tx_q <= {adr_pkg::CH0_GND_WORD, 16'h0000};
            end else begin
                tx_q <= {cmd_word, 16'h0000};
            end
        end else if (fall) begin
            tx_q <= {tx_q[adr_pkg::FRAME_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_q <= '0;
        end else if (rise) begin
            rx_q <= rx_next;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_byte_q       <= '0;
            rx_byte_valid_q <= 1'b0;
        end else begin
            rx_byte_valid_q <= byte_end;
            if (byte_end) begin
                rx_byte_q <= rx_q;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mid_q <= '0;
            low_q <= '0;
        end else if (byte_end && bit_cnt_q[4:3] == 2'h1) begin
            mid_q <= rx_q & adr_pkg::MID_MASK;
        end else if (byte_end && bit_cnt_q[4:3] == 2'h2) begin
            low_q <= rx_q & adr_pkg::LOW_MASK;
        end
    end

    assign joined = {mid_q, low_q} >> 1;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_q       <= '0;
            result_valid_q <= 1'b0;
        end else begin
            result_valid_q <= (state_q == adr_pkg::ADR_END) && tick;
            if (state_q == adr_pkg::ADR_END && tick) begin
                result_q <= joined[11:0];
            end
        end
    end

    assign link.sclk     = sclk_q;
    assign link.cs_n     = cs_n_q;
    assign link.mosi     = tx_q[adr_pkg::FRAME_BITS-1];
    assign busy          = (state_q != adr_pkg::ADR_IDLE);
    assign result        = result_q;
    assign result_valid  = result_valid_q;
    assign rx_byte       = rx_byte_q;
    assign rx_byte_valid = rx_byte_valid_q;
endmodule // adr_host_end
`default_nettype wire

//--- tb/adr_link_props.sv
// assertions on the serial link between host and converter
// assumes the host drives the link from ref_clk, reset active high
`timescale 1ns/1ns
`default_nettype none
module adr_link_props (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n,
    input wire logic miso
);
    logic       sclk_q;
    logic [9:0] half_q;
    logic [4:0] rise_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) sclk_q <= 1'b0;
        else sclk_q <= sclk;
    end
    // saturates so a long idle gap never wraps into a short phase
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) half_q <= 10'h000;
        else if (sclk != sclk_q) half_q <= 10'h000;
        else if (half_q != 10'h3FF) half_q <= half_q + 10'h001;
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) rise_q <= 5'h00;
        else if (cs_n) rise_q <= 5'h00;
        else if (sclk && !sclk_q) rise_q <= rise_q + 5'h01;
    end
    sequence s_quiet_clk; !sclk [*8]; endsequence
    sequence s_held_high; cs_n [*8]; endsequence
    property p_oe_tracks_sel; miso_oe_n == cs_n && (!cs_n || miso); endproperty
    property p_clk_idle; cs_n |-> !sclk; endproperty
    property p_half_min; (sclk != sclk_q) |-> half_q >= adr_pkg::SCLK_HALF_LAST; endproperty
    property p_cs_setup; $fell(cs_n) |-> s_quiet_clk; endproperty
    property p_rise_count; $rose(cs_n) |-> rise_q == 5'h18; endproperty
    property p_miso_hold; (sclk && sclk_q) |-> $stable(miso_o); endproperty
    property p_mosi_hold; $rose(sclk) |=> $stable(mosi) [*8]; endproperty
    property p_cs_gap; $rose(cs_n) |=> s_held_high; endproperty
    a_oe_tracks_sel: assert property (p_oe_tracks_sel)
        else $error("data enable not following select");
    a_clk_idle: assert property (p_clk_idle)
        else $error("serial clock active while deselected");
    a_half_min: assert property (p_half_min)
        else $error("serial clock phase too short");
    a_cs_setup: assert property (p_cs_setup)
        else $error("clock edge too soon after select");
    a_rise_count: assert property (p_rise_count)
        else $error("frame not 24 clocks long");
    a_miso_hold: assert property (p_miso_hold)
        else $error("converter data moved while clock high");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("host data moved after sample edge");
    a_cs_gap: assert property (p_cs_gap)
        else $error("deselect gap too short");
endmodule // adr_link_props
`default_nettype wire

//--- tb/test_adr_serial_result_reader.sv
// self-checking bench: host end and converter end joined by the link
// assumes a 250 MHz ref_clk; the serial clock comes from the host
`timescale 1ns/1ns
`default_nettype none
module test_adr_serial_result_reader;
    logic        ref_clk;
    logic        sys_rst;
    logic        start;
    logic        cmd_default;
    logic [7:0]  cmd_word;
    logic [11:0] sample_data;
    logic        busy;
    logic [11:0] result;
    logic        result_valid;
    logic [7:0]  rx_byte;
    logic        rx_byte_valid;
    logic [7:0]  dev_word;
    logic [7:0]  rx_q [0:7];
    logic [23:0] mosi_sr = 24'h000000;
    logic [23:0] miso_sr = 24'h000000;
    logic        dev_valid;
    int          rx_n = 0;
    int          res_n = 0;
    int          cycles = 0;
    int          cv_n = 0;
    int          bad_count;
    int          checks;
    adr_link_if link_if ();
    adr_host_end adr_host_end_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start),
        .cmd_default(cmd_default), .cmd_word(cmd_word), .busy(busy), .result(result),
        .result_valid(result_valid), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
        .link(link_if));
    adr_dev_end adr_dev_end_inst (.link(link_if), .sys_rst(sys_rst),
        .sample_data(sample_data), .cmd_word(dev_word), .cmd_valid(dev_valid));
    adr_link_props adr_link_props_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sclk(link_if.sclk), .cs_n(link_if.cs_n), .mosi(link_if.mosi),
        .miso_o(link_if.miso_o), .miso_oe_n(link_if.miso_oe_n), .miso(link_if.miso));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // two frames run near 64k cycles, so this ceiling only trips on a hang
    always @(posedge ref_clk) begin
        if (rx_byte_valid === 1'b1) begin
            rx_q[rx_n] <= rx_byte;
            rx_n <= rx_n + 1;
        end
        if (result_valid === 1'b1) res_n <= res_n + 1;
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            bad_count++;
            complete_run();
        end
    end
    always @(posedge link_if.sclk) begin
        if (link_if.cs_n === 1'b0) begin
            mosi_sr <= {mosi_sr[22:0], link_if.mosi};
            miso_sr <= {miso_sr[22:0], link_if.miso};
            // the word strobe must be seen at exactly one rising edge per frame
            if (dev_valid === 1'b1) cv_n <= cv_n + 1;
        end
    end
    task automatic run_frame(input logic dflt, input logic [7:0] word, input logic [11:0] smp);
        int         n;
        int         b;
        int         r;
        int         c;
        logic [7:0] w;
        w = dflt ? 8'h08 : word;
        b = rx_n;
        r = res_n;
        c = cv_n;
        @(posedge ref_clk);
        cmd_default <= dflt;
        cmd_word <= word;
        sample_data <= smp;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        @(negedge ref_clk);
        check({14'h0000, busy, link_if.cs_n}, 16'h0002);
        repeat (3000) @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        n = 0;
        while (res_n == r && n < 40000) begin
            @(negedge ref_clk);
            n++;
        end
        check({4'h0, result}, {4'h0, smp});
        check({8'h00, rx_q[b]}, 16'h0000);
        check({8'h00, rx_q[b+1] & 8'h1F}, {11'h000, smp[11:7]});
        check({8'h00, rx_q[b+2] & 8'hFE}, {8'h00, smp[6:0], 1'b0});
        check({8'h00, mosi_sr[23:16]}, {8'h00, w});
        check({4'h0, miso_sr[12:1]}, {4'h0, smp});
        check({8'h00, dev_word}, {8'h00, w});
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        check({13'h0000, busy, link_if.cs_n, link_if.sclk}, 16'h0002);
        // counted only once the frame is over, so an extra result, byte or word strobe from the frame shows up here
        check(16'(res_n - r), 16'h0001);
        check(16'(rx_n - b), 16'h0003);
        check(16'(cv_n - c), 16'h0001);
    endtask
    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        cmd_default = 1'b0;
        cmd_word = 8'h00;
        sample_data = 12'h000;
        bad_count = 0;
        checks = 0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        run_frame(1'b1, 8'hC3, 12'hFFF);
        run_frame(1'b0, 8'hC3, 12'h5A5);
        complete_run();
    end
endmodule // test_adr_serial_result_reader
`default_nettype wire
